// [src/orcm_pkg.sv]
// Shared constants for the over-range and auxiliary clock pin block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a single 250 MHz clock.
package orcm_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int SEL_W = 2;
  localparam int CH_N = 4;
  localparam int PIN_N = 7;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_THRESH = 5'h04;
  localparam logic [ADDR_W-1:0] REG_MIN_PULSE = 5'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_MASK = 5'h10;
  localparam logic [ADDR_W-1:0] REG_PINS = 5'h14;

  // Control register fields
  localparam int CTRL_OVERRIDE = 0;
  localparam int CTRL_CLK_DIS = 1;
  localparam int CTRL_C_SEL_LO = 2;
  localparam int CTRL_D_SEL_LO = 4;

  // Pin state register fields
  localparam int PINS_CFG_LO = 0;
  localparam int PINS_PLL = 2;
  localparam int PINS_PD = 3;
  localparam int PINS_SE_SEL = 4;
  localparam int PINS_C_ON = 5;
  localparam int PINS_D_ON = 6;

  // Index of each pin in the synchroniser vector
  localparam int PIN_CFG0 = 0;
  localparam int PIN_CFG1 = 1;
  localparam int PIN_PLL = 2;
  localparam int PIN_PD = 3;
  localparam int PIN_SE_SEL = 4;
  localparam int PIN_REF_DIFF = 5;
  localparam int PIN_REF_SE = 6;

  // Clock selection codes on the two-bit select
  localparam logic [SEL_W-1:0] SEL_FLAG = 2'h0;
  localparam logic [SEL_W-1:0] SEL_COPY = 2'h1;
  localparam logic [SEL_W-1:0] SEL_DIV2 = 2'h2;
  localparam logic [SEL_W-1:0] SEL_DIV4 = 2'h3;

  // Reset values
  localparam logic [15:0] THRESH_RST = 16'h0f00;
  localparam logic [15:0] MIN_PULSE_RST = 16'h0004;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic [CH_N-1:0] STATUS_RST = 4'h0;
  localparam logic [CH_N-1:0] MASK_RST = 4'h0;
endpackage : orcm_pkg

// [src/orcm_stretch.sv]
// One channel of fast over-range detection with minimum pulse length.
// Assumes the sample magnitude comes from logic on the same clock.
`timescale 1ns/1ps
module orcm_stretch #(
  parameter int SAMPLE_W = 12,
  parameter int PULSE_W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [SAMPLE_W-1:0] sample_mag,
  input wire logic [SAMPLE_W-1:0] threshold,
  input wire logic [PULSE_W-1:0] min_pulse,
  output logic flag
);
  typedef struct packed {
    logic flag;
    logic [PULSE_W-1:0] cnt;
    logic [PULSE_W-1:0] hi_cnt;
  } orcm_stretch_t;

  orcm_stretch_t s;
  orcm_stretch_t next_s;
  logic exceed;

  assign exceed = enable && (sample_mag > threshold);

  always_comb begin
    next_s = s;
    if (exceed) begin
      next_s.flag = 1'b1;
      // Restart the hold on every new crossing so the pulse stretches
      next_s.cnt = (min_pulse == '0) ? '0 : min_pulse - PULSE_W'(1);
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - PULSE_W'(1);
    end else begin
      next_s.flag = 1'b0;
    end
    if (s.flag && (s.hi_cnt != '1)) begin
      next_s.hi_cnt = s.hi_cnt + PULSE_W'(1);
    end else if (!s.flag) begin
      next_s.hi_cnt = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flag = s.flag;

  flag_follows_a: assert property (@(posedge clock) disable iff (!rst_n)
    exceed |=> flag)
    else $error("over-range flag did not rise after threshold crossing");

  min_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(s.flag) |-> (int'($past(s.hi_cnt)) + 1 >= int'($past(min_pulse))))
    else $error("over-range pulse shorter than programmed minimum");
endmodule : orcm_stretch

// [src/orcm_divider.sv]
// Divide-by-2 and divide-by-4 copies of the repeated reference clock.
// Assumes ref_edge is a one-cycle pulse per rising edge of the reference level.
`timescale 1ns/1ps
module orcm_divider (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ref_edge,
  output logic div2,
  output logic div4
);
  typedef struct packed {
    logic [1:0] cnt;
  } orcm_div_t;

  orcm_div_t s;
  orcm_div_t next_s;

  always_comb begin
    next_s = s;
    if (ref_edge) begin
      // A binary count gives equal high and low times on both outputs
      next_s.cnt = s.cnt + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign div2 = s.cnt[0];
  assign div4 = s.cnt[1];

  div_steady_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ref_edge |=> $stable(s.cnt))
    else $error("divided clock moved without a reference edge");
endmodule : orcm_divider

// [src/orcm_top.sv]
// Over-range status pins with optional auxiliary clock outputs on channels C and D.
// Assumes pins are asynchronous and sampled here; samples come from the local clock.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module orcm_top #(
  parameter int NUM_CHANNELS = 4,
  parameter int SAMPLE_W = 12,
  parameter int PULSE_W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [orcm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [orcm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [orcm_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [SAMPLE_W-1:0] sample_mag_ch_a,
  input wire logic [SAMPLE_W-1:0] sample_mag_ch_b,
  input wire logic [SAMPLE_W-1:0] sample_mag_ch_c,
  input wire logic [SAMPLE_W-1:0] sample_mag_ch_d,
  input wire logic [orcm_pkg::SEL_W-1:0] aux_clock_select,
  input wire logic pll_enable_pin,
  input wire logic power_down_pin,
  input wire logic ref_select_se_pin,
  input wire logic ref_clock_diff,
  input wire logic ref_clock_se,
  output logic ref_clock_repeater_out,
  output logic overrange_flag_ch_a,
  output logic overrange_flag_ch_b,
  output logic overrange_or_clk_ch_c,
  output logic overrange_or_clk_ch_d
);
  localparam int DW = orcm_pkg::DATA_W;
  localparam int SW = orcm_pkg::SEL_W;
  localparam int CN = orcm_pkg::CH_N;
  localparam int PN = orcm_pkg::PIN_N;

  typedef struct packed {
    logic [PN-1:0] meta;
    logic [PN-1:0] sync;
    logic ref_prev;
    logic override_en;
    logic clk_disable;
    logic [SW-1:0] c_sel_reg;
    logic [SW-1:0] d_sel_reg;
    logic [SAMPLE_W-1:0] threshold;
    logic [PULSE_W-1:0] min_pulse;
    logic [CN-1:0] status;
    logic [CN-1:0] mask;
    logic [CN-1:0] flag_prev;
    logic served;
    logic [DW-1:0] readdata;
    logic rep_out;
    logic out_c;
    logic out_d;
  } orcm_top_t;

  orcm_top_t s;
  orcm_top_t next_s;

  logic flag_a;
  logic flag_b;
  logic flag_c;
  logic flag_d;
  logic div2;
  logic div4;
  logic pll_s;
  logic pd_s;
  logic ref_lvl;
  logic ref_edge;
  logic allowed;
  logic [SW-1:0] pin_cfg;
  logic [SW-1:0] c_sel;
  logic [SW-1:0] d_sel;
  logic c_on;
  logic d_on;
  logic req;
  logic accept;
  logic [DW-1:0] wmask;
  logic [DW-1:0] rd_mux;
  logic [DW-1:0] ctrl_word;
  logic [DW-1:0] ctrl_new;
  logic [DW-1:0] thr_new;
  logic [DW-1:0] mp_new;
  logic [DW-1:0] mask_new;
  logic [CN-1:0] flags;
  logic [CN-1:0] rise;
  logic [CN-1:0] clr;

  orcm_stretch #(.SAMPLE_W(SAMPLE_W), .PULSE_W(PULSE_W)) u_str_a (
    .clock(clock),
    .rst_n(rst_n),
    .enable(1'b1),
    .sample_mag(sample_mag_ch_a),
    .threshold(s.threshold),
    .min_pulse(s.min_pulse),
    .flag(flag_a)
  );

  orcm_stretch #(.SAMPLE_W(SAMPLE_W), .PULSE_W(PULSE_W)) u_str_b (
    .clock(clock),
    .rst_n(rst_n),
    .enable(NUM_CHANNELS >= 2),
    .sample_mag(sample_mag_ch_b),
    .threshold(s.threshold),
    .min_pulse(s.min_pulse),
    .flag(flag_b)
  );

  orcm_stretch #(.SAMPLE_W(SAMPLE_W), .PULSE_W(PULSE_W)) u_str_c (
    .clock(clock),
    .rst_n(rst_n),
    .enable(NUM_CHANNELS >= 4),
    .sample_mag(sample_mag_ch_c),
    .threshold(s.threshold),
    .min_pulse(s.min_pulse),
    .flag(flag_c)
  );

  orcm_stretch #(.SAMPLE_W(SAMPLE_W), .PULSE_W(PULSE_W)) u_str_d (
    .clock(clock),
    .rst_n(rst_n),
    .enable(NUM_CHANNELS >= 4),
    .sample_mag(sample_mag_ch_d),
    .threshold(s.threshold),
    .min_pulse(s.min_pulse),
    .flag(flag_d)
  );

  orcm_divider u_div (
    .clock(clock),
    .rst_n(rst_n),
    .ref_edge(ref_edge & allowed),
    .div2(div2),
    .div4(div4)
  );

  function automatic logic pick_clock(input logic [SW-1:0] sel, input logic lvl,
                                      input logic d2, input logic d4);
    logic r;
    r = 1'b0;
    case (sel)
      orcm_pkg::SEL_COPY: r = lvl;
      orcm_pkg::SEL_DIV2: r = d2;
      orcm_pkg::SEL_DIV4: r = d4;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_clock

  // Pin decode and clock routing
  always_comb begin
    pll_s = s.sync[orcm_pkg::PIN_PLL];
    pd_s = s.sync[orcm_pkg::PIN_PD];
    pin_cfg = {s.sync[orcm_pkg::PIN_CFG1], s.sync[orcm_pkg::PIN_CFG0]};
    ref_lvl = s.sync[orcm_pkg::PIN_SE_SEL] ? s.sync[orcm_pkg::PIN_REF_SE]
                                           : s.sync[orcm_pkg::PIN_REF_DIFF];
    ref_edge = ref_lvl & ~s.ref_prev;
    allowed = pll_s & ~pd_s;
    c_sel = s.override_en ? s.c_sel_reg : pin_cfg;
    // Pins alone can only ask for an undivided copy on D
    d_sel = s.override_en ? s.d_sel_reg
          : ((pin_cfg != orcm_pkg::SEL_FLAG) ? orcm_pkg::SEL_COPY : orcm_pkg::SEL_FLAG);
    if (s.clk_disable) begin
      c_sel = orcm_pkg::SEL_FLAG;
      d_sel = orcm_pkg::SEL_FLAG;
    end
    c_on = allowed && (c_sel != orcm_pkg::SEL_FLAG);
    d_on = c_on && (d_sel != orcm_pkg::SEL_FLAG);
  end

  // Register bus decode
  always_comb begin
    req = avs_read | avs_write;
    accept = req & s.served;
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    ctrl_word = '0;
    ctrl_word[orcm_pkg::CTRL_OVERRIDE] = s.override_en;
    ctrl_word[orcm_pkg::CTRL_CLK_DIS] = s.clk_disable;
    ctrl_word[orcm_pkg::CTRL_C_SEL_LO +: SW] = s.c_sel_reg;
    ctrl_word[orcm_pkg::CTRL_D_SEL_LO +: SW] = s.d_sel_reg;
    ctrl_new = (ctrl_word & ~wmask) | (avs_writedata & wmask);
    thr_new = (DW'(s.threshold) & ~wmask) | (avs_writedata & wmask);
    mp_new = (DW'(s.min_pulse) & ~wmask) | (avs_writedata & wmask);
    mask_new = (DW'(s.mask) & ~wmask) | (avs_writedata & wmask);
    rd_mux = '0;
    case (avs_address)
      orcm_pkg::REG_CTRL: rd_mux = ctrl_word;
      orcm_pkg::REG_THRESH: rd_mux = DW'(s.threshold);
      orcm_pkg::REG_MIN_PULSE: rd_mux = DW'(s.min_pulse);
      orcm_pkg::REG_STATUS: rd_mux = DW'(s.status);
      orcm_pkg::REG_MASK: rd_mux = DW'(s.mask);
      orcm_pkg::REG_PINS: begin
        rd_mux[orcm_pkg::PINS_CFG_LO +: SW] = pin_cfg;
        rd_mux[orcm_pkg::PINS_PLL] = pll_s;
        rd_mux[orcm_pkg::PINS_PD] = pd_s;
        rd_mux[orcm_pkg::PINS_SE_SEL] = s.sync[orcm_pkg::PIN_SE_SEL];
        rd_mux[orcm_pkg::PINS_C_ON] = c_on;
        rd_mux[orcm_pkg::PINS_D_ON] = d_on;
      end
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.meta = {ref_clock_se, ref_clock_diff, ref_select_se_pin, power_down_pin,
                   pll_enable_pin, aux_clock_select};
    next_s.sync = s.meta;
    next_s.ref_prev = ref_lvl;
    flags = {flag_d, flag_c, flag_b, flag_a};
    next_s.flag_prev = flags;
    rise = flags & ~s.flag_prev;
    // Only bits that the read returned are cleared, so a new event is never lost
    clr = (accept && avs_read && (avs_address == orcm_pkg::REG_STATUS))
        ? s.readdata[CN-1:0] : '0;
    next_s.status = (s.status & ~clr) | rise;
    next_s.served = req & ~s.served;
    if (req && !s.served && avs_read) begin
      next_s.readdata = rd_mux;
    end
    if (accept && avs_write) begin
      case (avs_address)
        orcm_pkg::REG_CTRL: begin
          next_s.override_en = ctrl_new[orcm_pkg::CTRL_OVERRIDE];
          next_s.clk_disable = ctrl_new[orcm_pkg::CTRL_CLK_DIS];
          next_s.c_sel_reg = ctrl_new[orcm_pkg::CTRL_C_SEL_LO +: SW];
          next_s.d_sel_reg = ctrl_new[orcm_pkg::CTRL_D_SEL_LO +: SW];
        end
        orcm_pkg::REG_THRESH: next_s.threshold = thr_new[SAMPLE_W-1:0];
        orcm_pkg::REG_MIN_PULSE: next_s.min_pulse = mp_new[PULSE_W-1:0];
        orcm_pkg::REG_MASK: next_s.mask = mask_new[CN-1:0];
        default: next_s.mask = s.mask;
      endcase
    end
    next_s.rep_out = allowed & ref_lvl;
    next_s.out_c = c_on ? pick_clock(c_sel, ref_lvl, div2, div4) : flag_c;
    next_s.out_d = d_on ? pick_clock(d_sel, ref_lvl, div2, div4) : flag_d;
    if (!allowed) begin
      next_s.out_c = (c_sel != orcm_pkg::SEL_FLAG) ? 1'b0 : flag_c;
      next_s.out_d = (c_sel != orcm_pkg::SEL_FLAG) ? 1'b0 : flag_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.c_sel_reg <= orcm_pkg::SEL_RST;
      s.d_sel_reg <= orcm_pkg::SEL_RST;
      s.threshold <= orcm_pkg::THRESH_RST[SAMPLE_W-1:0];
      s.min_pulse <= orcm_pkg::MIN_PULSE_RST[PULSE_W-1:0];
      s.status <= orcm_pkg::STATUS_RST;
      s.mask <= orcm_pkg::MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest = req & ~s.served;
  assign avs_readdata = s.readdata;
  assign irq = |(s.status & s.mask);
  assign ref_clock_repeater_out = s.rep_out;
  assign overrange_flag_ch_a = flag_a;
  assign overrange_flag_ch_b = flag_b;
  assign overrange_or_clk_ch_c = s.out_c;
  assign overrange_or_clk_ch_d = s.out_d;

  ch_b_unused_a: assert property (@(posedge clock) disable iff (!rst_n)
    (NUM_CHANNELS < 2) |-> !overrange_flag_ch_b)
    else $error("channel B flag active in single channel variant");

  ch_cd_unused_a: assert property (@(posedge clock) disable iff (!rst_n)
    ((NUM_CHANNELS < 4) && !c_on && !d_on) |=> !overrange_or_clk_ch_c && !overrange_or_clk_ch_d)
    else $error("channel C or D flag active outside quad variant");

  c_flag_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    (c_sel == orcm_pkg::SEL_FLAG) |=> (overrange_or_clk_ch_c == $past(flag_c)))
    else $error("channel C pin not carrying its over-range flag");

  c_needs_pll_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!pll_s && (c_sel != orcm_pkg::SEL_FLAG)) |=> !overrange_or_clk_ch_c)
    else $error("channel C clock driven without PLL enable");

  c_copy_clk_a: assert property (@(posedge clock) disable iff (!rst_n)
    (c_on && (c_sel == orcm_pkg::SEL_COPY)) |=> (overrange_or_clk_ch_c == $past(ref_lvl)))
    else $error("channel C undivided copy does not follow reference");

  c_div4_clk_a: assert property (@(posedge clock) disable iff (!rst_n)
    (c_on && (c_sel == orcm_pkg::SEL_DIV4)) |=> (overrange_or_clk_ch_c == $past(div4)))
    else $error("channel C divide-by-four not selected");

  d_pin_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!s.override_en && !s.clk_disable && allowed && (pin_cfg != orcm_pkg::SEL_FLAG))
      |-> d_on && (d_sel == orcm_pkg::SEL_COPY))
    else $error("configuration pins did not give D an undivided copy");

  d_with_c_a: assert property (@(posedge clock) disable iff (!rst_n)
    d_on |-> c_on)
    else $error("channel D clock without channel C clock");

  pd_stops_clk_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pd_s && (c_sel != orcm_pkg::SEL_FLAG)) |=> !ref_clock_repeater_out
      && !overrange_or_clk_ch_c && !overrange_or_clk_ch_d)
    else $error("clock outputs running during power-down");

  rep_select_a: assert property (@(posedge clock) disable iff (!rst_n)
    allowed |=> (ref_clock_repeater_out == $past(s.sync[orcm_pkg::PIN_SE_SEL]
      ? s.sync[orcm_pkg::PIN_REF_SE] : s.sync[orcm_pkg::PIN_REF_DIFF])))
    else $error("repeater output does not follow selected reference");
endmodule : orcm_top

// [tb/orcm_board_model.sv]
// Board-side model that watches the status and clock pins of the block.
// Assumes pins are registered on the same clock; counts are cleared by clr.
`timescale 1ns/1ps
module orcm_board_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_c,
  input wire logic pin_d,
  input wire logic pin_rep,
  output logic [15:0] edges_c,
  output logic [15:0] edges_d,
  output logic [15:0] edges_rep,
  output logic [15:0] run_a,
  output logic [15:0] run_b,
  output logic [15:0] run_c,
  output logic [15:0] run_d
);
  logic [4:0] pins;
  logic [4:0] prev;
  logic [15:0] cur [5];
  logic [15:0] edges [5];
  logic [15:0] run [5];

  assign pins = {pin_rep, pin_d, pin_c, pin_b, pin_a};
  // A board needing one clock takes it from pin C, so C is the primary count
  assign edges_c = edges[2];
  assign edges_d = edges[3];
  assign edges_rep = edges[4];
  assign run_a = run[0];
  assign run_b = run[1];
  assign run_c = run[2];
  assign run_d = run[3];

  // Runs keep counting across clr so a measured pulse is never cut short
  always @(posedge clock or negedge rst_n) begin
    for (int i = 0; i < 5; i++) begin
      if (!rst_n) begin
        prev[i] <= 1'b0;
        cur[i] <= 16'h0;
        edges[i] <= 16'h0;
        run[i] <= 16'h0;
      end else begin
        prev[i] <= pins[i];
        if (pins[i]) begin
          cur[i] <= cur[i] + 16'h1;
        end else begin
          cur[i] <= 16'h0;
        end
        if (clr) begin
          edges[i] <= 16'h0;
          run[i] <= 16'h0;
        end else begin
          if (pins[i] && !prev[i]) begin
            edges[i] <= edges[i] + 16'h1;
          end
          if (!pins[i] && prev[i]) begin
            run[i] <= cur[i];
          end
        end
      end
    end
  end
endmodule : orcm_board_model

// [tb/tb_overrange_clockout_mux.sv]
// Self-checking bench for the over-range and auxiliary clock pin block.
// Assumes the design package is compiled first; references are made by the bench.
`timescale 1ns/1ps
module tb_overrange_clockout_mux;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [orcm_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [11:0] mag_a = 12'h0;
  logic [11:0] mag_b = 12'h0;
  logic [11:0] mag_c = 12'h0;
  logic [11:0] mag_d = 12'h0;
  logic [1:0] aux_clock_select = 2'h1;
  logic pll_enable_pin = 1'b1;
  logic power_down_pin = 1'b0;
  logic ref_select_se_pin = 1'b0;
  logic ref_clock_diff = 1'b0;
  logic ref_clock_se = 1'b0;
  logic ref_clock_repeater_out, pin_a, pin_b, pin_c, pin_d;
  logic clr = 1'b0;
  logic [15:0] edges_c, edges_d, edges_rep, run_a, run_b, run_c, run_d;
  logic [2:0] ref_div = 3'h0;
  logic [31:0] dummy;
  logic [3:0] avs_byteenable = 4'hf;
  logic one_a, one_b, one_c, one_d;
  logic [3:0] one_seen = 4'h0;
  int error_cnt = 0;
  int tests_run = 0;
  int cycle_cnt = 0;

  always #2 clock = ~clock;

  // Reference periods of 16 and 8 cycles divide the 128-cycle count window
  always @(posedge clock) begin
    ref_div <= ref_div + 3'h1;
    if (ref_div == 3'h7) ref_clock_diff <= ~ref_clock_diff;
    if (ref_div[1:0] == 2'h3) ref_clock_se <= ~ref_clock_se;
  end

  orcm_top DUT (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .sample_mag_ch_a(mag_a),
    .sample_mag_ch_b(mag_b), .sample_mag_ch_c(mag_c), .sample_mag_ch_d(mag_d),
    .aux_clock_select(aux_clock_select), .pll_enable_pin(pll_enable_pin),
    .power_down_pin(power_down_pin), .ref_select_se_pin(ref_select_se_pin),
    .ref_clock_diff(ref_clock_diff), .ref_clock_se(ref_clock_se),
    .ref_clock_repeater_out(ref_clock_repeater_out), .overrange_flag_ch_a(pin_a),
    .overrange_flag_ch_b(pin_b), .overrange_or_clk_ch_c(pin_c),
    .overrange_or_clk_ch_d(pin_d));

  orcm_board_model board (.clock(clock), .rst_n(rst_n), .clr(clr), .pin_a(pin_a),
    .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d), .pin_rep(ref_clock_repeater_out),
    .edges_c(edges_c), .edges_d(edges_d), .edges_rep(edges_rep), .run_a(run_a),
    .run_b(run_b), .run_c(run_c), .run_d(run_d));

  // Single channel variant on the same bus and pins: only its A flag may rise
  orcm_top #(.NUM_CHANNELS(1)) DUT_single (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .irq(), .sample_mag_ch_a(mag_a), .sample_mag_ch_b(mag_b),
    .sample_mag_ch_c(mag_c), .sample_mag_ch_d(mag_d),
    .aux_clock_select(aux_clock_select), .pll_enable_pin(pll_enable_pin),
    .power_down_pin(power_down_pin), .ref_select_se_pin(ref_select_se_pin),
    .ref_clock_diff(ref_clock_diff), .ref_clock_se(ref_clock_se),
    .ref_clock_repeater_out(), .overrange_flag_ch_a(one_a), .overrange_flag_ch_b(one_b),
    .overrange_or_clk_ch_c(one_c), .overrange_or_clk_ch_d(one_d));

  always @(posedge clock) begin
    one_seen <= clr ? 4'h0 : (one_seen | {one_d, one_c, one_b, one_a});
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge clock) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus_xfer(input logic wr, input logic [orcm_pkg::ADDR_W-1:0] addr,
      input logic [31:0] wdata, input logic [3:0] be, output logic [31:0] rdata);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    // Only waitrequest low ends this wait; a hang is left to the bench timeout
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus_xfer

  task automatic bus_write(input logic [orcm_pkg::ADDR_W-1:0] addr, input logic [31:0] d);
    bus_xfer(1'b1, addr, d, 4'hf, dummy);
  endtask : bus_write

  task automatic read_check(input logic [orcm_pkg::ADDR_W-1:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    bus_xfer(1'b0, addr, 32'h0, 4'hf, rd);
    check(rd, exp);
  endtask : read_check

  task automatic check_reset_values();
    read_check(orcm_pkg::REG_CTRL, 32'h0);
    read_check(orcm_pkg::REG_THRESH, 32'(orcm_pkg::THRESH_RST));
    // Lane 0 only: the upper threshold bits must survive
    bus_xfer(1'b1, orcm_pkg::REG_THRESH, 32'h0000_01ab, 4'h1, dummy);
    read_check(orcm_pkg::REG_THRESH, 32'h0000_0fab);
    read_check(orcm_pkg::REG_MIN_PULSE, 32'(orcm_pkg::MIN_PULSE_RST));
    read_check(orcm_pkg::REG_MASK, 32'h0);
    bus_write(orcm_pkg::REG_STATUS, 32'hf);
    read_check(orcm_pkg::REG_STATUS, 32'h0);
    bus_write(5'h18, 32'hffff_ffff);
    read_check(5'h18, 32'h0);
  endtask : check_reset_values

  task automatic pulse_all(input logic [11:0] v);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    mag_a <= v;
    mag_b <= v;
    mag_c <= v;
    mag_d <= v;
    @(posedge clock);
    mag_a <= 12'h0;
    mag_b <= 12'h0;
    mag_c <= 12'h0;
    mag_d <= 12'h0;
    repeat (14) @(posedge clock);
  endtask : pulse_all

  // One crossing cycle must give exactly the programmed pulse on every channel
  task automatic flags_and_irq();
    aux_clock_select <= orcm_pkg::SEL_FLAG;
    bus_write(orcm_pkg::REG_THRESH, 32'h100);
    bus_write(orcm_pkg::REG_MIN_PULSE, 32'h5);
    repeat (8) @(posedge clock);
    pulse_all(12'h101);
    check(32'(run_a), 32'h5);
    check(32'(run_b), 32'h5);
    check(32'(run_c), 32'h5);
    check(32'(run_d), 32'h5);
    check({28'h0, one_seen}, 32'h1);
    pulse_all(12'h100);
    check(32'(run_a), 32'h0);
    check({31'h0, irq}, 32'h0);
    bus_write(orcm_pkg::REG_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    read_check(orcm_pkg::REG_STATUS, 32'hf);
    check({31'h0, irq}, 32'h0);
    read_check(orcm_pkg::REG_STATUS, 32'h0);
  endtask : flags_and_irq

  // Counts rising edges over 128 cycles once the selection has settled
  task automatic clock_row(input logic [1:0] sel, input logic pll, input logic pd,
      input logic se, input logic [31:0] ctrl, input int ec, input int ed, input int er,
      input int erun);
    bus_write(orcm_pkg::REG_CTRL, ctrl);
    aux_clock_select <= sel;
    pll_enable_pin <= pll;
    power_down_pin <= pd;
    ref_select_se_pin <= se;
    repeat (80) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (129) @(posedge clock);
    check(32'(edges_c), 32'(ec));
    check(32'(edges_d), 32'(ed));
    check(32'(edges_rep), 32'(er));
    check(32'(run_c), 32'(erun));
    read_check(orcm_pkg::REG_PINS, {25'h0, ed != 0, ec != 0, se, pd, pll, sel});
  endtask : clock_row

  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check_reset_values();
    clock_row(2'h1, 1'b1, 1'b0, 1'b0, 32'h0, 8, 8, 8, 8);
    flags_and_irq();
    clock_row(2'h2, 1'b1, 1'b0, 1'b0, 32'h0, 4, 8, 8, 16);
    clock_row(2'h3, 1'b1, 1'b0, 1'b0, 32'h0, 2, 8, 8, 32);
    clock_row(2'h1, 1'b0, 1'b0, 1'b0, 32'h0, 0, 0, 0, 0);
    clock_row(2'h1, 1'b1, 1'b1, 1'b0, 32'h0, 0, 0, 0, 0);
    clock_row(2'h0, 1'b1, 1'b0, 1'b0, 32'h0, 0, 0, 8, 0);
    clock_row(2'h0, 1'b1, 1'b0, 1'b0, 32'h25, 8, 4, 8, 8);
    clock_row(2'h0, 1'b1, 1'b0, 1'b0, 32'h31, 0, 0, 8, 0);
    clock_row(2'h3, 1'b1, 1'b0, 1'b0, 32'h2, 0, 0, 8, 0);
    clock_row(2'h1, 1'b1, 1'b0, 1'b1, 32'h0, 16, 16, 16, 4);
    close_out();
  end
endmodule : tb_overrange_clockout_mux
